// ### hw/synth_regs_pkg.sv
package synth_regs_pkg;

   // ********************************************************************
   // Serial word layout.
   // ********************************************************************
   localparam int WORD_BITS = 32;
   localparam int READ_BIT = 31;
   localparam int ADDR_MSB = 2;
   localparam logic [5:0] WORD_COUNT = 6'h20;

   // ********************************************************************
   // Register addresses and values after reset.
   // ********************************************************************
   localparam logic [2:0] ADDR_MISC = 3'h3;
   localparam logic [2:0] ADDR_DIVCONV = 3'h4;
   localparam logic [2:0] ADDR_STATUS = 3'h6;
   localparam logic [31:0] MISC_RESET = 32'h00000043;
   localparam logic [31:0] DIVCONV_RESET = 32'h00000004;

   // ********************************************************************
   // Field positions.
   // ********************************************************************
   localparam int MISC_HIGHZ_BIT = 4;
   localparam int MISC_CNTRST_BIT = 3;
   localparam int STATUS_POR_BIT = 11;
   localparam int STATUS_VALID_BIT = 10;
   localparam int STATUS_RESULT_LSB = 3;
   localparam int RESULT_BITS = 7;

   typedef enum logic [1:0] {
      DIV_OFF = 2'b00,
      DIV_FASTLOCK = 2'b01,
      DIV_PHASE = 2'b10,
      DIV_ADCCLK = 2'b11
   } divider_mode_t;

   typedef enum logic [2:0] {
      CONV_OFF = 3'b000,
      CONV_TEMP = 3'b001
   } converter_mode_t;

   typedef struct packed {
      logic readReq;
      logic [8:0] spare;
      logic ref_stage_off;
      logic [1:0] divider_function_sel;
      logic [11:0] divider_count;
      logic [2:0] converter_source_sel;
      logic conversion_go;
      logic [2:0] addr;
   } div_conv_word_t;

endpackage : synth_regs_pkg

// ### hw/serial_port_shifter.sv
`timescale 1ns/100ps
`default_nettype none

module serial_port_shifter (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic serialClk,
   input wire logic serialData,
   input wire logic latchEnable,
   input wire logic [31:0] loadWord,
   input wire logic loadEn,
   output logic [31:0] word,
   output logic wordValid,
   output logic readbackData,
   output logic readDone
);

   // ********************************************************************
   // Edge detection on the port pins.
   // ********************************************************************
   logic prevClk;
   logic prevLe;
   logic [31:0] shiftIn;
   logic [31:0] shiftOut;
   logic [5:0] outCount;
   wire clkRise = serialClk & ~prevClk;
   wire clkFall = ~serialClk & prevClk;
   wire leRise = latchEnable & ~prevLe;
   wire outStep = clkFall & ~latchEnable & (outCount != 6'h00);
   wire lastOut = outStep & (outCount == 6'h01);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prevClk <= 1'b0;
         prevLe <= 1'b1;
         shiftIn <= 32'h00000000;
         word <= 32'h00000000;
         wordValid <= 1'b0;
      end else begin
         prevClk <= serialClk;
         prevLe <= latchEnable;
         wordValid <= leRise;
         if (clkRise && !latchEnable) begin
            shiftIn <= {shiftIn[30:0], serialData};
         end
         if (leRise) begin
            word <= shiftIn;
         end
      end
   end

   // Readback leaves MSB first; each falling edge presents the next bit.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         shiftOut <= 32'h00000000;
         outCount <= 6'h00;
         readbackData <= 1'b0;
         readDone <= 1'b0;
      end else begin
         readDone <= lastOut;
         if (loadEn) begin
            shiftOut <= loadWord;
            readbackData <= loadWord[31];
            outCount <= synth_regs_pkg::WORD_COUNT;
         end else if (outStep) begin
            shiftOut <= {shiftOut[30:0], 1'b0};
            readbackData <= shiftOut[30];
            outCount <= outCount - 6'h01;
         end
      end
   end

endmodule : serial_port_shifter

`default_nettype wire

// ### hw/conversion_tracker.sv
`timescale 1ns/100ps
`default_nettype none

module conversion_tracker #(
   parameter int RESULT_W = synth_regs_pkg::RESULT_BITS
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic startReq,
   input wire logic convDone,
   input wire logic [RESULT_W-1:0] convResult,
   output logic convStart,
   output logic conversion_valid,
   output logic [RESULT_W-1:0] resultHeld
);

   typedef enum logic [0:0] {
      CT_IDLE = 1'b0,
      CT_BUSY = 1'b1
   } conv_state_t;

   conv_state_t state;
   conv_state_t next_state;

   always_comb begin
      case (state)
         CT_IDLE: next_state = startReq ? CT_BUSY : CT_IDLE;
         CT_BUSY: next_state = convDone ? CT_IDLE : CT_BUSY;
         default: next_state = CT_IDLE;
      endcase
   end

   // A new start while busy restarts; the old result is not trusted.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= CT_IDLE;
         convStart <= 1'b0;
         conversion_valid <= 1'b0;
         resultHeld <= '0;
      end else begin
         state <= startReq ? CT_BUSY : next_state; // RULE_09
         convStart <= startReq; // RULE_09
         if (startReq) begin
            conversion_valid <= 1'b0; // RULE_11
         end else if (state == CT_BUSY && convDone) begin
            conversion_valid <= 1'b1; // RULE_11
            resultHeld <= convResult; // RULE_11
         end
      end
   end

endmodule : conversion_tracker

`default_nettype wire

// ### hw/synth_ctrl_status_regs.sv
// Notes on behaviour
// RULE_01: Misc bit 4 high floats charge-pump output.
// RULE_02: Misc bit 3 high holds both counters reset.
// RULE_03: Word bit 31 selects read, else write.
// RULE_04: Host writes zeros into bits 30:22.
// RULE_05: Bit 21 high turns reference stage off.
// RULE_06: Bits 20:19 pick divider function.
// RULE_07: Bits 18:7 give divider count, nonzero.
// RULE_08: Bits 6:4 pick converter source, 000/001.
// RULE_09: Writing bit 3 as one starts conversion; the code starts one only when bits 6:4 are also 001.
// RULE_10: Status bit 11 shows power-on not read.
// RULE_11: Status bit 10 low while converting.
// RULE_12: Low three address bits route each word.
// RULE_13: Completed status read clears power-on flag.
`timescale 1ns/100ps
`default_nettype none

module synth_ctrl_status_regs #(
   parameter int RESULT_W = synth_regs_pkg::RESULT_BITS
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic serialClk,
   input wire logic serialData,
   input wire logic latchEnable,
   input wire logic convDone,
   input wire logic [RESULT_W-1:0] convResult,
   output logic readbackData,
   output logic cpHighZ,
   output logic countersHeldReset,
   output logic ref_stage_off,
   output logic [1:0] divider_function_sel,
   output logic dividerOff,
   output logic dividerFastLock,
   output logic dividerPhaseAdjust,
   output logic dividerAdcClock,
   output logic [11:0] divider_count,
   output logic [2:0] converter_source_sel,
   output logic tempSensorSel,
   output logic convStart,
   output logic conversion_valid
);

   // ********************************************************************
   // Decoding helpers.
   // ********************************************************************
   function automatic logic hitsAddr(input logic [31:0] w,
                                     input logic [2:0] a);
      hitsAddr = (w[synth_regs_pkg::ADDR_MSB:0] == a); // RULE_12
   endfunction : hitsAddr

   function automatic logic isRead(input logic [31:0] w);
      isRead = w[synth_regs_pkg::READ_BIT]; // RULE_03
   endfunction : isRead

   // ********************************************************************
   // Serial port.
   // ********************************************************************
   logic [31:0] rxWord;
   logic rxValid;
   logic [31:0] loadWord;
   logic loadEn;
   logic readDone;

   serial_port_shifter port_u (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .serialClk(serialClk),
      .serialData(serialData),
      .latchEnable(latchEnable),
      .loadWord(loadWord),
      .loadEn(loadEn),
      .word(rxWord),
      .wordValid(rxValid),
      .readbackData(readbackData),
      .readDone(readDone)
   );

   // ********************************************************************
   // Register storage.
   // ********************************************************************
   logic [31:0] misc_control;
   synth_regs_pkg::div_conv_word_t clock_divider_and_converter_control;
   logic porFlag;
   logic statusPending;
   logic [RESULT_W-1:0] resultHeld;

   wire writeReq = rxValid & ~isRead(rxWord); // RULE_03
   wire readReq = rxValid & isRead(rxWord); // RULE_03
   wire writeMisc = writeReq & hitsAddr(rxWord,
                                        synth_regs_pkg::ADDR_MISC);
   wire writeDivConv = writeReq & hitsAddr(rxWord,
                                           synth_regs_pkg::ADDR_DIVCONV);
   wire readStatus = readReq & hitsAddr(rxWord,
                                        synth_regs_pkg::ADDR_STATUS);

   // Stored words keep the read bit at zero so readback shows the
   // register rather than the request that fetched it.
   wire [31:0] next_misc = {1'b0, rxWord[30:0]};
   wire [31:0] next_divConv = {1'b0, rxWord[30:0]};

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         misc_control <= synth_regs_pkg::MISC_RESET;
      end else if (writeMisc) begin
         misc_control <= next_misc; // RULE_12
      end
   end

   // The unused bits are stored as written; the host keeps them zero.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         clock_divider_and_converter_control <=
            synth_regs_pkg::DIVCONV_RESET;
      end else if (writeDivConv) begin
         clock_divider_and_converter_control <= next_divConv; // RULE_04
      end
   end

   // ********************************************************************
   // Readback selection.
   // ********************************************************************
   logic [31:0] statusWord;
   logic [31:0] readSel;

   always_comb begin
      statusWord = 32'h00000000;
      statusWord[synth_regs_pkg::STATUS_POR_BIT] = porFlag; // RULE_10
      statusWord[synth_regs_pkg::STATUS_VALID_BIT] = conversion_valid;
      statusWord[synth_regs_pkg::STATUS_RESULT_LSB +: RESULT_W] =
         resultHeld; // RULE_11
      statusWord[synth_regs_pkg::ADDR_MSB:0] = synth_regs_pkg::ADDR_STATUS;
   end

   // Registers outside this block answer with zero.
   always_comb begin
      case (rxWord[synth_regs_pkg::ADDR_MSB:0])
         synth_regs_pkg::ADDR_MISC: readSel = misc_control;
         synth_regs_pkg::ADDR_DIVCONV:
            readSel = clock_divider_and_converter_control;
         synth_regs_pkg::ADDR_STATUS: readSel = statusWord;
         default: readSel = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         loadEn <= 1'b0;
      end else begin
         loadEn <= readReq; // RULE_12
      end
   end

   // The word is captured once, so later writes cannot alter a readback
   // that is already leaving the port.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         loadWord <= 32'h00000000;
      end else if (readReq) begin
         loadWord <= readSel; // RULE_12
      end
   end

   // ********************************************************************
   // Power-on flag.
   // ********************************************************************
   // The flag only clears once all 32 bits have left the port, so an
   // aborted readback does not lose the power-on indication.
   wire dropPending = readReq | readDone;
   wire clearPor = readDone & statusPending; // RULE_13

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         statusPending <= 1'b0;
      end else if (readStatus) begin
         statusPending <= 1'b1;
      end else if (dropPending) begin
         statusPending <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         porFlag <= 1'b1; // RULE_10
      end else if (clearPor) begin
         porFlag <= 1'b0; // RULE_13
      end
   end

   // ********************************************************************
   // Conversion control.
   // ********************************************************************
   synth_regs_pkg::div_conv_word_t newCtl;
   assign newCtl = next_divConv;
   wire goBit = newCtl.conversion_go;
   wire goSource =
      (newCtl.converter_source_sel == synth_regs_pkg::CONV_TEMP);

   wire goReq = writeDivConv & goBit & goSource; // RULE_09

   conversion_tracker #(
      .RESULT_W(RESULT_W)
   ) conv_u (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .startReq(goReq),
      .convDone(convDone),
      .convResult(convResult),
      .convStart(convStart),
      .conversion_valid(conversion_valid),
      .resultHeld(resultHeld)
   );

   // ********************************************************************
   // Control outputs.
   // ********************************************************************
   synth_regs_pkg::div_conv_word_t ctl;
   assign ctl = clock_divider_and_converter_control;
   wire [1:0] fnSel = ctl.divider_function_sel;

   wire next_cpHighZ = misc_control[synth_regs_pkg::MISC_HIGHZ_BIT];
   wire next_countersHeldReset =
      misc_control[synth_regs_pkg::MISC_CNTRST_BIT];

   wire next_refStageOff = ctl.ref_stage_off;
   wire [11:0] next_dividerCount = ctl.divider_count;
   wire [2:0] next_sourceSel = ctl.converter_source_sel;
   wire next_tempSensorSel =
      (ctl.converter_source_sel == synth_regs_pkg::CONV_TEMP);
   wire [3:0] fnHot;

   // Bit n of the decode is high for function code n, so the enables
   // keep the order of the encoding.
   genvar f;
   generate
      for (f = 0; f < 4; f++) begin : g_fn
         assign fnHot[f] = (fnSel == 2'(f)); // RULE_06
      end
   endgenerate

   // Outputs follow the stored fields one cycle later so that every pin
   // comes from a flip-flop.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cpHighZ <= synth_regs_pkg::MISC_RESET[synth_regs_pkg::MISC_HIGHZ_BIT];
         countersHeldReset <=
            synth_regs_pkg::MISC_RESET[synth_regs_pkg::MISC_CNTRST_BIT];
      end else begin
         cpHighZ <= next_cpHighZ; // RULE_01
         countersHeldReset <= next_countersHeldReset; // RULE_02
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ref_stage_off <= 1'b0;
         divider_function_sel <= 2'b00;
         divider_count <= 12'h000;
      end else begin
         ref_stage_off <= next_refStageOff; // RULE_05
         divider_function_sel <= fnSel; // RULE_06
         divider_count <= next_dividerCount; // RULE_07
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dividerOff <= 1'b1;
         dividerFastLock <= 1'b0;
         dividerPhaseAdjust <= 1'b0;
         dividerAdcClock <= 1'b0;
      end else begin
         dividerOff <= fnHot[0]; // RULE_06
         dividerFastLock <= fnHot[1]; // RULE_06
         dividerPhaseAdjust <= fnHot[2]; // RULE_06
         dividerAdcClock <= fnHot[3]; // RULE_06
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         converter_source_sel <= 3'h0;
         tempSensorSel <= 1'b0;
      end else begin
         converter_source_sel <= next_sourceSel; // RULE_08
         tempSensorSel <= next_tempSensorSel; // RULE_08
      end
   end

endmodule : synth_ctrl_status_regs

`default_nettype wire

// ### tb/synth_ctrl_status_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module synth_ctrl_status_regs_sva #(
   parameter int RESULT_W = 7
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic serialClk,
   input wire logic latchEnable,
   input wire logic convDone,
   input wire logic readbackData,
   input wire logic cpHighZ,
   input wire logic countersHeldReset,
   input wire logic ref_stage_off,
   input wire logic [1:0] divider_function_sel,
   input wire logic dividerOff,
   input wire logic dividerFastLock,
   input wire logic dividerPhaseAdjust,
   input wire logic dividerAdcClock,
   input wire logic [11:0] divider_count,
   input wire logic [2:0] converter_source_sel,
   input wire logic tempSensorSel,
   input wire logic convStart,
   input wire logic conversion_valid
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   AST_DIV_ONEHOT: assert property (
      {dividerAdcClock, dividerPhaseAdjust, dividerFastLock, dividerOff}
      == 4'h1 << divider_function_sel) else $error("divider decode");
   AST_TEMP_SEL: assert property (
      tempSensorSel == (converter_source_sel == 3'h1)) else $error("source");
   AST_START_CLEARS: assert property (
      convStart |-> ##[0:1] !conversion_valid) else $error("valid kept");
   AST_START_SRC: assert property (
      convStart |-> ##[0:1] tempSensorSel) else $error("start source");
   AST_START_PULSE: assert property (
      convStart |=> !convStart) else $error("start pulse");
   AST_VALID_CAUSE: assert property (
      $rose(conversion_valid) |-> $past(convDone)) else $error("valid cause");
   AST_HOLD: assert property (
      (!latchEnable)[*5] |-> $stable({cpHighZ, countersHeldReset,
      ref_stage_off, divider_count, divider_function_sel}))
      else $error("output moved in frame");
   AST_RB_HOLD: assert property (
      (serialClk && !latchEnable)[*3] |-> $stable(readbackData))
      else $error("readback moved");
endmodule : synth_ctrl_status_regs_sva
`default_nettype wire

// ### tb/serial_host.sv
`timescale 1ns/100ps
`default_nettype none
module serial_host (
   input wire logic clk_sys,
   input wire logic readbackData,
   output logic serialClk,
   output logic serialData,
   output logic latchEnable
);
   initial begin
      serialClk = 1'b0;
      serialData = 1'b0;
      latchEnable = 1'b1;
   end
   // Four clocks a phase, so the sampled port clock never slips an edge.
   task automatic frame(input logic [31:0] w, output logic [31:0] rd);
      @(negedge clk_sys) latchEnable = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         serialData = w[i];
         repeat (4) @(negedge clk_sys);
         rd[i] = readbackData;
         serialClk = 1'b1;
         repeat (4) @(negedge clk_sys);
         serialClk = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
      latchEnable = 1'b1;
      // A released line shows the inverse, so a stale bit never passes.
      serialData = ~w[0];
      repeat (6) @(negedge clk_sys);
   endtask : frame
endmodule : serial_host
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int RESULT_W = synth_regs_pkg::RESULT_BITS;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic convDone = 1'b0;
   logic [RESULT_W-1:0] convResult = '0;
   wire logic serialClk, serialData, latchEnable, readbackData, cpHighZ;
   wire logic countersHeldReset, ref_stage_off, dividerOff, dividerFastLock;
   wire logic dividerPhaseAdjust, dividerAdcClock, tempSensorSel, convStart;
   wire logic conversion_valid;
   wire logic [1:0] divider_function_sel;
   wire logic [11:0] divider_count;
   wire logic [2:0] converter_source_sel;
   int errors = 0;
   int checks = 0;
   int seed = 32'h9ec593be;
   int starts = 0;
   int seenStarts = 0;
   logic [31:0] misc = 32'h00000043;
   logic [31:0] divconv = 32'h00000004;
   logic [31:0] rd, w;
   logic por = 1'b1;
   logic valid = 1'b0;
   logic busy = 1'b0;
   logic [6:0] res = 7'h00;
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (convStart === 1'b1) seenStarts++;
   synth_ctrl_status_regs #(.RESULT_W(RESULT_W)) synth_ctrl_status_regs_i (
      .clk_sys(clk_sys), .rst_b(rst_b), .serialClk(serialClk),
      .serialData(serialData), .latchEnable(latchEnable),
      .convDone(convDone), .convResult(convResult),
      .readbackData(readbackData), .cpHighZ(cpHighZ),
      .countersHeldReset(countersHeldReset), .ref_stage_off(ref_stage_off),
      .divider_function_sel(divider_function_sel), .dividerOff(dividerOff),
      .dividerFastLock(dividerFastLock),
      .dividerPhaseAdjust(dividerPhaseAdjust),
      .dividerAdcClock(dividerAdcClock), .divider_count(divider_count),
      .converter_source_sel(converter_source_sel),
      .tempSensorSel(tempSensorSel), .convStart(convStart),
      .conversion_valid(conversion_valid));
   serial_host serial_host_i (.clk_sys(clk_sys), .readbackData(readbackData),
      .serialClk(serialClk), .serialData(serialData),
      .latchEnable(latchEnable));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic cmp_outs();
      chk(cpHighZ, misc[4]);
      chk(countersHeldReset, misc[3]);
      chk(ref_stage_off, divconv[21]);
      chk(divider_function_sel, divconv[20:19]);
      chk({dividerAdcClock, dividerPhaseAdjust, dividerFastLock, dividerOff},
         32'h1 << divconv[20:19]);
      chk(divider_count, divconv[18:7]);
      chk(converter_source_sel, divconv[6:4]);
      chk(tempSensorSel, divconv[6:4] == 3'h1);
      chk(conversion_valid, valid);
   endtask : cmp_outs
   task automatic wr(input logic [31:0] v);
      serial_host_i.frame(v, rd);
      if (v[2:0] == 3'h3) misc = v;
      if (v[2:0] == 3'h4) begin
         divconv = v;
         if (v[3] && v[6:4] == 3'h1) begin
            busy = 1'b1;
            valid = 1'b0;
            starts++;
         end
      end
      cmp_outs();
   endtask : wr
   task automatic rdreg(input logic [2:0] a);
      logic [31:0] e;
      e = (a == 3'h3) ? misc : (a == 3'h4) ? divconv : 32'h0;
      if (a == 3'h6) e = {20'h0, por, valid, res, 3'h6};
      serial_host_i.frame({1'b1, 28'h0, a}, rd);
      serial_host_i.frame(32'h00000007, rd);
      chk(rd, e);
      if (a == 3'h6) por = 1'b0;
   endtask : rdreg
   task automatic done();
      logic [6:0] r;
      r = 7'($random(seed));
      convResult = r;
      convDone = 1'b1;
      @(negedge clk_sys) convDone = 1'b0;
      if (busy) begin
         valid = 1'b1;
         res = r;
         busy = 1'b0;
      end
      repeat (3) @(negedge clk_sys);
      cmp_outs();
   endtask : done
   task automatic stop_test();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   initial begin
      #800000;
      errors++;
      stop_test();
   end
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (2) @(negedge clk_sys);
      cmp_outs();
      rdreg(3'h3);
      rdreg(3'h4);
      rdreg(3'h6);
      rdreg(3'h6);
      $display("Test reset and power-on flag done");
      for (int i = 0; i < 4; i++) begin
         w = $random(seed);
         w[31:18] = 14'h0;
         w[4:3] = i[1:0];
         w[2:0] = 3'h3;
         wr(w);
      end
      rdreg(3'h3);
      for (int m = 0; m < 4; m++) begin
         w = $random(seed);
         w[31:22] = 10'h0;
         w[20:19] = m[1:0];
         w[18:7] = (m == 0) ? 12'h001 : (m == 3) ? 12'hfff : w[18:7] | 12'h1;
         w[6:3] = {2'b00, m[0], 1'b0};
         w[2:0] = 3'h4;
         wr(w);
         rdreg(3'h4);
      end
      $display("Test control writes done");
      wr(32'h0000fff6);
      wr(32'h0000fff5);
      rdreg(3'h5);
      rdreg(3'h0);
      rdreg(3'h6);
      $display("Test refused addresses done");
      done();
      wr(32'h0000008c);
      wr(32'h0000009c);
      rdreg(3'h6);
      done();
      rdreg(3'h6);
      wr(32'h0000009c);
      rdreg(3'h6);
      done();
      rdreg(3'h6);
      chk(seenStarts, starts);
      $display("Test conversion done");
      stop_test();
   end
endmodule : tb
bind synth_ctrl_status_regs synth_ctrl_status_regs_sva #(.RESULT_W(RESULT_W))
   chk_i (.clk_sys(clk_sys), .rst_b(rst_b), .serialClk(serialClk),
   .latchEnable(latchEnable), .convDone(convDone),
   .readbackData(readbackData), .cpHighZ(cpHighZ),
   .countersHeldReset(countersHeldReset), .ref_stage_off(ref_stage_off),
   .divider_function_sel(divider_function_sel), .dividerOff(dividerOff),
   .dividerFastLock(dividerFastLock), .dividerPhaseAdjust(dividerPhaseAdjust),
   .dividerAdcClock(dividerAdcClock), .divider_count(divider_count),
   .converter_source_sel(converter_source_sel),
   .tempSensorSel(tempSensorSel), .convStart(convStart),
   .conversion_valid(conversion_valid));
`default_nettype wire
